// *** dv/fault_action_and_window_watchdog_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module fault_action_and_window_watchdog_tb;
    // A short tick keeps the watchdog intervals used here to a few hundred cycles.
    localparam int TICKS = 4;
    logic                          sys_clk      = 1'b0;
    logic                          nrst         = 1'b0;
    logic [7:0]                    fault_active = 8'h00;
    logic                          pin          = 1'b0;
    fault_wdog_pkg::reg_req_t      reg_req;
    fault_wdog_pkg::fault_action_t action;
    logic [15:0]                   reg_rdata;
    logic                          level;
    logic                          adc_en;
    logic                          wdt_error;
    logic                          soft_reset;
    logic                          trim_pulse;
    int                            fails   = 0;
    int                            checks  = 0;
    int                            wd_hits = 0;
    int                            base;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (wdt_error === 1'b1) wd_hits++;

    reg_host_model u_reg_host_model (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

    fault_action_and_window_watchdog #(.TICK_CYCLES(TICKS)) u_fault_action_and_window_watchdog (
        .sys_clk(sys_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .fault_active(fault_active), .shared_polarity_input_pin(pin), .effective_alarm_level(level),
        .dac_output_action(action), .shared_pin_adc_enable(adc_en), .wdt_error(wdt_error),
        .soft_reset(soft_reset), .trim_reload_on_soft_reset(trim_pulse));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] d;
        u_reg_host_model.read(a, d);
        check(d, exp);
    endtask : rdchk

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_cycles

    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    initial begin
        #200_000;
        fails++;
        report_and_stop();
    end

    initial begin
        logic [2:0] v;
        wait_cycles(15);
        #1 check({14'h0000, action}, 16'h0002);
        @(posedge sys_clk) nrst <= 1'b1;
        rdchk(fault_wdog_pkg::OFS_MISC, 16'h0000);
        rdchk(fault_wdog_pkg::OFS_ACTION, 16'h8020);
        rdchk(fault_wdog_pkg::OFS_WDT, 16'h0018);
        rdchk(7'h7f, 16'h0000);
        // Fields k and k+4 share code k mod 4, so a swap between fields within one half shows up as a wrong action.
        u_reg_host_model.write(fault_wdog_pkg::OFS_ACTION, 16'he4e4);
        rdchk(fault_wdog_pkg::OFS_ACTION, 16'he4e4);
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk) fault_active <= 8'h01 << k;
            wait_cycles(2);
            #1 check({14'h0000, action}, 16'(k % 4));
        end
        @(posedge sys_clk) fault_active <= 8'h00;
        wait_cycles(2);
        #1 check({14'h0000, action}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            v = i[2:0];
            u_reg_host_model.write(fault_wdog_pkg::OFS_MISC, {14'h0000, v[2], v[0]});
            @(posedge sys_clk) pin <= v[1];
            wait_cycles(5);
            #1 check({15'h0000, level}, {15'h0000, v[2] | (v[1] & ~v[0])});
            check({15'h0000, adc_en}, {15'h0000, v[0]});
        end
        u_reg_host_model.write(fault_wdog_pkg::OFS_MISC, 16'h0004);
        u_reg_host_model.write(fault_wdog_pkg::OFS_SOFT_RESET, 16'h005a);
        #1 check({14'h0000, soft_reset, trim_pulse}, 16'h0000);
        u_reg_host_model.write(fault_wdog_pkg::OFS_SOFT_RESET, 16'h00ad);
        #1 check({14'h0000, soft_reset, trim_pulse}, 16'h0003);
        rdchk(fault_wdog_pkg::OFS_MISC, 16'h0000);
        u_reg_host_model.write(fault_wdog_pkg::OFS_SOFT_RESET, 16'h00ad);
        #1 check({14'h0000, soft_reset, trim_pulse}, 16'h0002);
        // The key write restored the action defaults, so a lone self-diagnostic fault must pick the alarm.
        @(posedge sys_clk) fault_active <= 8'h80;
        wait_cycles(2);
        #1 check({14'h0000, action}, 16'h0002);
        @(posedge sys_clk) fault_active <= 8'h00;
        base = wd_hits;
        u_reg_host_model.write(fault_wdog_pkg::OFS_WDT, 16'h0001);
        wait_cycles(250);
        check(16'(wd_hits - base), 16'h0000);
        wait_cycles(20);
        check(16'(wd_hits - base), 16'h0001);
        base = wd_hits;
        u_reg_host_model.write(fault_wdog_pkg::OFS_WDT, 16'h0001);
        repeat (3) begin
            wait_cycles(200);
            u_reg_host_model.write(fault_wdog_pkg::OFS_ACTION, 16'he4e4);
        end
        check(16'(wd_hits - base), 16'h0000);
        u_reg_host_model.write(fault_wdog_pkg::OFS_WDT, 16'h0003);
        base = wd_hits;
        u_reg_host_model.write(fault_wdog_pkg::OFS_WDT, 16'h0003);
        wait_cycles(3);
        check(16'(wd_hits - base), 16'h0001);
        base = wd_hits;
        wait_cycles(150);
        u_reg_host_model.write(fault_wdog_pkg::OFS_ACTION, 16'he4e4);
        wait_cycles(100);
        check(16'(wd_hits - base), 16'h0000);
        wait_cycles(20);
        check(16'(wd_hits - base), 16'h0001);
        u_reg_host_model.write(fault_wdog_pkg::OFS_WDT, 16'h000b);
        wait_cycles(2);
        base = wd_hits;
        repeat (2) begin
            wait_cycles(400);
            u_reg_host_model.write(fault_wdog_pkg::OFS_WDT, 16'h000b);
        end
        wait_cycles(3);
        check(16'(wd_hits - base), 16'h0000);
        // The disabling write still lands inside the lower limit, so it raises one early error.
        base = wd_hits;
        u_reg_host_model.write(fault_wdog_pkg::OFS_WDT, 16'h0000);
        wait_cycles(3);
        check(16'(wd_hits - base), 16'h0001);
        base = wd_hits;
        wait_cycles(600);
        check(16'(wd_hits - base), 16'h0000);
        report_and_stop();
    end
endmodule : fault_action_and_window_watchdog_tb
`default_nettype wire

// *** dv/reg_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module reg_host_model (
    input  wire logic                              sys_clk,   // System clock.
    output fault_wdog_pkg::reg_req_t               reg_req,   // Register request.
    input  wire logic [fault_wdog_pkg::DATA_W-1:0] reg_rdata  // Read data.
);
    initial reg_req = '0;

    // Released address and data carry the inverse, so a stale value never passes for a live one.
    task automatic write(input logic [6:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : write

    task automatic read(input logic [6:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
        #1;
        d = reg_rdata;
    endtask : read
endmodule : reg_host_model
`default_nettype wire

// *** hw/fault_action_and_window_watchdog.sv ***
`timescale 1ns/10ps
`default_nettype none
module fault_action_and_window_watchdog #(
    parameter int TICK_CYCLES = fault_wdog_pkg::TICK_CYCLES
) (
    input  wire logic                                   sys_clk,                   // System clock.
    input  wire logic                                   nrst,                      // Async reset, low.
    input  wire fault_wdog_pkg::reg_req_t               reg_req,                   // Register request.
    output logic [fault_wdog_pkg::DATA_W-1:0]           reg_rdata,                 // Read data.
    input  wire logic [fault_wdog_pkg::NUM_SRC-1:0]     fault_active,              // Alarm levels per source.
    input  wire logic                                   shared_polarity_input_pin, // Shared pin level.
    output logic                                        effective_alarm_level,     // Alarm output level.
    output fault_wdog_pkg::fault_action_t               dac_output_action,         // Output behaviour.
    output logic                                        shared_pin_adc_enable,     // Pin routed to ADC.
    output logic                                        wdt_error,                 // Watchdog error pulse.
    output logic                                        soft_reset,                // Software reset pulse.
    output logic                                        trim_reload_on_soft_reset  // Trim reload pulse.
);

    logic [fault_wdog_pkg::DATA_W-1:0]     misc_fault_config_r;
    logic [fault_wdog_pkg::DATA_W-1:0]     fault_action_select_r;
    logic [fault_wdog_pkg::DATA_W-1:0]     watchdog_window_config_r;
    logic [fault_wdog_pkg::DATA_W-1:0]     reg_rdata_r;
    logic [fault_wdog_pkg::DATA_W-1:0]     rdata_nxt;
    logic                                  pin_s1_r;
    logic                                  pin_s2_r;
    logic                                  level_r;
    logic                                  level_nxt;
    fault_wdog_pkg::fault_action_t         action_r;
    fault_wdog_pkg::fault_action_t         action_nxt;
    logic [fault_wdog_pkg::TICK_CNT_W-1:0] tick_cnt_r;
    logic                                  tick;
    logic [fault_wdog_pkg::TIMER_W-1:0]    timer_r;
    logic                                  overrun_r;
    logic                                  wdt_error_r;
    logic                                  soft_reset_r;
    logic                                  trim_reload_r;
    logic                                  key_write;
    logic                                  service;
    logic                                  early;
    logic                                  late;
    logic                                  watchdog_enable_bit;
    logic [1:0]                            lo_code;
    logic [2:0]                            up_code;
    logic [fault_wdog_pkg::TIMER_W-1:0]    up_ticks;
    logic [fault_wdog_pkg::TIMER_W-1:0]    lo_ticks;

    // Action field of one fault source.
    function automatic fault_wdog_pkg::fault_action_t field_of(input logic [15:0] act, input int idx);
        fault_wdog_pkg::fault_action_t f;
        f = fault_wdog_pkg::fault_action_t'(act[2*idx +: 2]);
        return f;
    endfunction : field_of

    assign watchdog_enable_bit   = watchdog_window_config_r[fault_wdog_pkg::WATCHDOG_ENABLE_BIT_BIT];
    assign lo_code  = watchdog_window_config_r[fault_wdog_pkg::WATCHDOG_LOWER_LIMIT_LSB +: 2];
    assign up_code  = watchdog_window_config_r[fault_wdog_pkg::WATCHDOG_UPPER_LIMIT_LSB +: 3];
    assign up_ticks = fault_wdog_pkg::WATCHDOG_UPPER_LIMIT_TICKS[up_code];
    assign lo_ticks = fault_wdog_pkg::WATCHDOG_LOWER_LIMIT_TICKS[lo_code];

    assign key_write = reg_req.wr && reg_req.addr == fault_wdog_pkg::OFS_SOFT_RESET
                       && reg_req.wdata[7:0] == fault_wdog_pkg::SOFT_RESET_KEY;

    // Register writes. A key write returns the configuration to its reset values.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            misc_fault_config_r      <= fault_wdog_pkg::MISC_RST;
            fault_action_select_r    <= fault_wdog_pkg::ACTION_RST;
            watchdog_window_config_r <= fault_wdog_pkg::WDT_RST;
        end else if (key_write) begin
            misc_fault_config_r      <= fault_wdog_pkg::MISC_RST;
            fault_action_select_r    <= fault_wdog_pkg::ACTION_RST;
            watchdog_window_config_r <= fault_wdog_pkg::WDT_RST;
        end else if (reg_req.wr) begin
            if (reg_req.addr == fault_wdog_pkg::OFS_MISC) begin
                misc_fault_config_r <= {13'h0000, reg_req.wdata[fault_wdog_pkg::MISC_USED_W-1:0]};
            end
            if (reg_req.addr == fault_wdog_pkg::OFS_ACTION) begin
                fault_action_select_r <= reg_req.wdata;
            end
            if (reg_req.addr == fault_wdog_pkg::OFS_WDT) begin
                watchdog_window_config_r <= {10'h000, reg_req.wdata[fault_wdog_pkg::WDT_USED_W-1:0]};
            end
        end
    end

    always_comb begin
        rdata_nxt = reg_rdata_r;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                fault_wdog_pkg::OFS_MISC:   rdata_nxt = misc_fault_config_r;
                fault_wdog_pkg::OFS_ACTION: rdata_nxt = fault_action_select_r;
                fault_wdog_pkg::OFS_WDT:    rdata_nxt = watchdog_window_config_r;
                default:                    rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_r <= 16'h0000;
        end else begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    // Software reset strobes; the trim bit is sampled as it stood before the key write.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            soft_reset_r  <= 1'b0;
            trim_reload_r <= 1'b0;
        end else begin
            soft_reset_r  <= key_write;
            trim_reload_r <= key_write && misc_fault_config_r[fault_wdog_pkg::MISC_TRIM_BIT];
        end
    end

    // The shared pin is asynchronous to sys_clk.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= shared_polarity_input_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    // With the pin given to the ADC its level is masked off the polarity.
    assign level_nxt = misc_fault_config_r[fault_wdog_pkg::MISC_POL_BIT]
                       | (pin_s2_r & ~misc_fault_config_r[fault_wdog_pkg::MISC_PINADC_BIT]);

    // Among active sources the strongest action wins: high impedance over alarm over clear.
    always_comb begin
        action_nxt = fault_wdog_pkg::ACT_NONE;
        for (int k = 0; k < fault_wdog_pkg::NUM_SRC; k++) begin
            if (fault_active[k] && field_of(fault_action_select_r, k) > action_nxt) begin
                action_nxt = field_of(fault_action_select_r, k);
            end
        end
    end

    // Hardware reset shows the alarm action; the level flop can only hold a constant then.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            level_r  <= 1'b0;
            action_r <= fault_wdog_pkg::ACT_ALARM;
        end else begin
            level_r  <= level_nxt;
            action_r <= action_nxt;
        end
    end

    // Servicing writes; with the window on, only the watchdog register counts.
    assign service = reg_req.wr && (lo_code == 2'h0 || reg_req.addr == fault_wdog_pkg::OFS_WDT);
    assign early   = lo_code != 2'h0 && timer_r < lo_ticks;
    assign late    = timer_r > up_ticks && !overrun_r;

    // The divider restarts on service so every interval starts on a tick boundary.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_r <= '0;
        end else if (!watchdog_enable_bit || service || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 17'h00001;
        end
    end

    assign tick = tick_cnt_r == fault_wdog_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

    // The timer stops one past the upper limit so a late error is raised only once.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            timer_r <= '0;
        end else if (!watchdog_enable_bit) begin
            timer_r <= '0;
        end else if (service) begin
            timer_r <= '0;
        end else if (tick && timer_r <= up_ticks) begin
            timer_r <= timer_r + 13'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            overrun_r   <= 1'b0;
            wdt_error_r <= 1'b0;
        end else begin
            overrun_r   <= watchdog_enable_bit && !service && (overrun_r || timer_r > up_ticks);
            wdt_error_r <= watchdog_enable_bit && ((service && early) || late);
        end
    end

    assign reg_rdata                 = reg_rdata_r;
    assign effective_alarm_level     = level_r;
    assign dac_output_action         = action_r;
    assign shared_pin_adc_enable     = misc_fault_config_r[fault_wdog_pkg::MISC_PINADC_BIT];
    assign wdt_error                 = wdt_error_r;
    assign soft_reset                = soft_reset_r;
    assign trim_reload_on_soft_reset = trim_reload_r;

    property p_trim_reload;
        @(posedge sys_clk) disable iff (!nrst)
        key_write && misc_fault_config_r[fault_wdog_pkg::MISC_TRIM_BIT] |=> trim_reload_r && soft_reset_r;
    endproperty
    a_trim_reload: assert property (p_trim_reload) else $error("trim reload missing");

    property p_no_trim_reload;
        @(posedge sys_clk) disable iff (!nrst)
        !misc_fault_config_r[fault_wdog_pkg::MISC_TRIM_BIT] |=> !trim_reload_r;
    endproperty
    a_no_trim_reload: assert property (p_no_trim_reload) else $error("unexpected trim reload");

    property p_level;
        @(posedge sys_clk) disable iff (!nrst)
        $stable(misc_fault_config_r) && $stable(pin_s2_r) |=>
            effective_alarm_level == ($past(misc_fault_config_r[1]) | ($past(pin_s2_r) & ~$past(misc_fault_config_r[0])));
    endproperty
    a_level: assert property (p_level) else $error("alarm level wrong");

    property p_pin_ignored;
        @(posedge sys_clk) disable iff (!nrst)
        misc_fault_config_r[0] && !misc_fault_config_r[1] && $stable(misc_fault_config_r) |=> !effective_alarm_level;
    endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("pin leaks into level");

    property p_hiz_wins;
        @(posedge sys_clk) disable iff (!nrst)
        (fault_active & {fault_action_select_r[15], fault_action_select_r[13], fault_action_select_r[11],
                         fault_action_select_r[9], fault_action_select_r[7], fault_action_select_r[5],
                         fault_action_select_r[3], fault_action_select_r[1]}
                      & {fault_action_select_r[14], fault_action_select_r[12], fault_action_select_r[10],
                         fault_action_select_r[8], fault_action_select_r[6], fault_action_select_r[4],
                         fault_action_select_r[2], fault_action_select_r[0]}) != 8'h00
        |=> dac_output_action == fault_wdog_pkg::ACT_HIZ;
    endproperty
    a_hiz_wins: assert property (p_hiz_wins) else $error("high impedance not selected");

    property p_alarm_self_diag;
        @(posedge sys_clk) disable iff (!nrst)
        fault_active == 8'h80 && fault_action_select_r[15:14] == 2'h2 |=> dac_output_action == fault_wdog_pkg::ACT_ALARM;
    endproperty
    a_alarm_self_diag: assert property (p_alarm_self_diag) else $error("alarm action not applied");

    property p_quiet;
        @(posedge sys_clk) disable iff (!nrst)
        fault_active == 8'h00 |=> dac_output_action == fault_wdog_pkg::ACT_NONE;
    endproperty
    a_quiet: assert property (p_quiet) else $error("action without fault");

    property p_defaults_after_key;
        @(posedge sys_clk) disable iff (!nrst)
        key_write |=> fault_action_select_r == 16'h8020 && watchdog_window_config_r == 16'h0018;
    endproperty
    a_defaults_after_key: assert property (p_defaults_after_key) else $error("defaults not restored");

    property p_key_only;
        @(posedge sys_clk) disable iff (!nrst)
        reg_req.wr && reg_req.addr == 7'h07 && reg_req.wdata[7:0] != 8'had |=> !soft_reset_r;
    endproperty
    a_key_only: assert property (p_key_only) else $error("soft reset without key");

    property p_disabled_idle;
        @(posedge sys_clk) disable iff (!nrst)
        !watchdog_enable_bit |=> timer_r == 13'h0000 && !wdt_error_r;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("watchdog active while off");

    property p_restart;
        @(posedge sys_clk) disable iff (!nrst)
        watchdog_enable_bit && reg_req.wr && lo_code == 2'h0 && !key_write |=> timer_r == 13'h0000;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");

    property p_other_write_ignored;
        @(posedge sys_clk) disable iff (!nrst)
        watchdog_enable_bit && lo_code != 2'h0 && reg_req.wr && reg_req.addr != 7'h11 && reg_req.addr != 7'h07
            && !tick && timer_r != 13'h0000 |=> timer_r == $past(timer_r);
    endproperty
    a_other_write_ignored: assert property (p_other_write_ignored) else $error("foreign write served");

    property p_early_error;
        @(posedge sys_clk) disable iff (!nrst)
        watchdog_enable_bit && lo_code != 2'h0 && reg_req.wr && reg_req.addr == 7'h11 && timer_r < lo_ticks
        |=> wdt_error_r && timer_r == 13'h0000;
    endproperty
    a_early_error: assert property (p_early_error) else $error("early service not flagged");

    property p_late_error;
        @(posedge sys_clk) disable iff (!nrst)
        watchdog_enable_bit && $rose(overrun_r) |-> wdt_error_r && $past(timer_r) == up_ticks + 13'h0001;
    endproperty
    a_late_error: assert property (p_late_error) else $error("overrun not flagged at limit");

    property p_tick_spacing;
        @(posedge sys_clk) disable iff (!nrst)
        tick |=> !tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent");

endmodule : fault_action_and_window_watchdog
`default_nettype wire

// *** hw/fault_wdog_pkg.sv ***
// Summary of operation
// - Trim reload bit set: software reset also reloads factory trim; clear: no reload.
// - Effective alarm level is polarity bit OR (shared pin AND NOT pin ADC enable).
// - Alarm level drives output during hardware reset and for faults selecting alarm voltage.
// - Pin ADC enable low: pin sets polarity, ADC sees ground; high: pin is ADC input.
// - Action codes: 0 none, 1 clear code, 2 alarm voltage, 3 high impedance.
// - Bits 15-14 act on self-diagnostic faults; reset value selects alarm voltage.
// - Bits 13-12 act on die temperature outside limits; reset value is none.
// - Bits 11-10 act on second input outside limits; reset value is none.
// - Bits 9-8 act on first input outside limits; reset value is none.
// - Bits 7-6 act on frame check or watchdog errors; reset value is none.
// - Bits 5-4 act on reference faults; reset value selects alarm voltage.
// - Bits 3-2 act on overheat error above 130 C; reset value is none.
// - Bits 1-0 act on overheat warning above 85 C; reset value is none.
// - Watchdog counts 1200 Hz ticks, oscillator divided by 1024; limits in ticks.
// - Enabled watchdog errors when timer exceeds upper limit; eight codes, default 3.
// - With lower limit off, a write to any register restarts the timer.
// - Lower limit codes: off, 64, 128, 512 ticks; resets to off.
// - Enable bit switches timer and checks off or on; resets to off.
// - Software reset starts only when the key value is written to the reset field.
package fault_wdog_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        ACT_NONE  = 2'h0,
        ACT_CLEAR = 2'h1,
        ACT_ALARM = 2'h2,
        ACT_HIZ   = 2'h3
    } fault_action_t;

    localparam logic [ADDR_W-1:0] OFS_SOFT_RESET = 7'h07;
    localparam logic [ADDR_W-1:0] OFS_MISC       = 7'h0b;
    localparam logic [ADDR_W-1:0] OFS_ACTION     = 7'h10;
    localparam logic [ADDR_W-1:0] OFS_WDT        = 7'h11;

    localparam logic [DATA_W-1:0] MISC_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] ACTION_RST = 16'h8020;
    localparam logic [DATA_W-1:0] WDT_RST    = 16'h0018;

    localparam int MISC_TRIM_BIT   = 2;
    localparam int MISC_POL_BIT    = 1;
    localparam int MISC_PINADC_BIT = 0;
    localparam int WATCHDOG_UPPER_LIMIT_LSB      = 3;
    localparam int WATCHDOG_LOWER_LIMIT_LSB      = 1;
    localparam int WATCHDOG_ENABLE_BIT_BIT      = 0;
    localparam int MISC_USED_W     = 3;
    localparam int WDT_USED_W      = 6;

    // Fault source k owns action field bits [2k+1:2k].
    localparam int NUM_SRC            = 8;
    localparam int SRC_OVERHEAT_WARN  = 0;
    localparam int SRC_OVERHEAT_ERR   = 1;
    localparam int SRC_REFERENCE      = 2;
    localparam int SRC_FRAME_TIMEOUT  = 3;
    localparam int SRC_FIRST_INPUT    = 4;
    localparam int SRC_SECOND_INPUT   = 5;
    localparam int SRC_DIE_TEMP       = 6;
    localparam int SRC_SELF_DIAG      = 7;

    localparam logic [7:0] SOFT_RESET_KEY = 8'had;

    localparam int SYS_CLK_HZ  = 100_000_000;
    localparam int OSC_HZ      = 1_228_800;
    localparam int OSC_DIV     = 1024;
    localparam int TICK_HZ     = OSC_HZ / OSC_DIV;
    localparam int TICK_CYCLES = SYS_CLK_HZ / TICK_HZ;
    localparam int TICK_CNT_W  = 17;
    localparam int TIMER_W     = 13;

    localparam logic [7:0][TIMER_W-1:0] WATCHDOG_UPPER_LIMIT_TICKS = {13'h1800, 13'h1000, 13'h0c00, 13'h0800,
                                                        13'h0400, 13'h0200, 13'h0080, 13'h0040};
    localparam logic [3:0][TIMER_W-1:0] WATCHDOG_LOWER_LIMIT_TICKS = {13'h0200, 13'h0080, 13'h0040, 13'h0000};
endpackage : fault_wdog_pkg
